// file: hw/pcu_core.sv
`timescale 1ns/10ps
`include "pcu_params.svh"

//------------------------------------------------------------------
// What this block does
//------------------------------------------------------------------
// What this block does
// - Interrupt inputs: direct or counter mode
// - Global disable: keep counting, suppress interrupt
// - New set value taken at mask re-enable
// - Present value refreshed: scan, completion, read
// - Input interrupt snapshots counter values
// - Quadrature counts every edge, times four
// - Up, up/down or pulse+direction inputs
// - Compare against up to 48 targets
// - 8 or 32 ranges, enter/leave interrupt
// - Linear mode or ring mode
// - 32-bit count, signed or unsigned
// - Ring max from power-up, init updates
// - Ring load above max sets error
// - Value load during high-freq sample flags unreliable
module pcu_core
    import pcu_pkg::*;
#(
    parameter int TGT_N    = `PCU_TGT_NUM,
    parameter int RNG_N    = `PCU_RNG_NUM_MAX,
    parameter int IRQ_N    = `PCU_IRQ_NUM,
    parameter int ICW      = `PCU_IRQ_CNT_W,
    parameter int SAMPLE_C = `PCU_SAMPLE_CYC
) (
    // Clock and reset
    input  wire logic                 core_clk_i,
    input  wire logic                 rst_i,
    // Counter pins (phase A/up/pulse, phase B/down/direction)
    input  wire logic                 pin_a_i,
    input  wire logic                 pin_b_i,
    // Counter configuration
    input  wire pcu_mode_t            mode_i,
    input  wire logic                 ring_mode_i,
    input  wire pcu_cnt_t             ring_max_cfg_i,
    input  wire logic                 range32_i,
    // Value init instruction
    input  wire logic                 value_init_instr_i,
    input  wire logic                 init_sel_max_i,
    input  wire pcu_cnt_t             init_value_i,
    // Target and range tables
    input  wire pcu_cnt_t             target_i [TGT_N],
    input  wire logic [TGT_N-1:0]     target_en_i,
    input  wire pcu_cnt_t             rng_lo_i [RNG_N],
    input  wire pcu_cnt_t             rng_hi_i [RNG_N],
    // Frequency sampling
    input  wire logic                 high_freq_mode_i,
    input  wire logic                 value_read_instr_i,
    // Interrupt inputs
    input  wire logic [IRQ_N-1:0]     irq_pin_i,
    input  wire logic [IRQ_N-1:0]     irq_count_mode_i,
    input  wire logic                 interrupt_disable_instr_i,
    input  wire logic [IRQ_N-1:0]     interrupt_mask_set_instr_i,
    input  wire logic [ICW-1:0]       irq_set_value_i [IRQ_N],
    input  wire logic [IRQ_N-1:0]     irq_init_i,
    input  wire logic [ICW-1:0]       irq_init_value_i [IRQ_N],
    // Pulse output present value to snapshot
    input  wire pcu_cnt_t             pulse_pv_i,
    // Results
    output pcu_cnt_t                  count_o,
    output logic                      count_signed_o,
    output logic [TGT_N-1:0]          target_hit_o,
    output logic [RNG_N-1:0]          range_evt_o,
    output logic [RNG_N-1:0]          in_range_o,
    output logic                      pv_change_error_flag_o,
    output logic                      result_unreliable_flag_o,
    output pcu_cnt_t                  freq_o,
    output logic [IRQ_N-1:0]          irq_o,
    output logic [ICW-1:0]            irq_pv_o [IRQ_N],
    output pcu_cnt_t                  snap_count_o,
    output pcu_cnt_t                  snap_pulse_o
);
    localparam int SCW = $clog2(SAMPLE_C + 1);

    //------------------------------------------------------------------
    // Input synchronisers
    //------------------------------------------------------------------
    logic [1:0]       a_s_r, b_s_r;
    logic             a_d_r, b_d_r;
    logic [IRQ_N-1:0] irq_s1_r, irq_s2_r, irq_d_r;
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            a_s_r    <= '0;
            b_s_r    <= '0;
            a_d_r    <= 1'b0;
            b_d_r    <= 1'b0;
            irq_s1_r <= '0;
            irq_s2_r <= '0;
            irq_d_r  <= '0;
        end else begin
            a_s_r    <= {a_s_r[0], pin_a_i};
            b_s_r    <= {b_s_r[0], pin_b_i};
            a_d_r    <= a_s_r[1];
            b_d_r    <= b_s_r[1];
            irq_s1_r <= irq_pin_i;
            irq_s2_r <= irq_s1_r;
            irq_d_r  <= irq_s2_r;
        end
    end

    //------------------------------------------------------------------
    // Step decode
    //------------------------------------------------------------------
    logic a, b, a_rise, b_rise, a_edge, b_edge;
    logic inc, dec;
    assign a      = a_s_r[1];
    assign b      = b_s_r[1];
    assign a_rise = a & ~a_d_r;
    assign b_rise = b & ~b_d_r;
    assign a_edge = a ^ a_d_r;
    assign b_edge = b ^ b_d_r;
    always_comb begin
        inc = 1'b0;
        dec = 1'b0;
        case (mode_i)
            PCU_QUAD: begin
                // Every edge of both phases; A leading means up
                if (a_edge && !b_edge) begin
                    inc = (a != b);
                    dec = (a == b);
                end else if (b_edge && !a_edge) begin
                    inc = (a == b);
                    dec = (a != b);
                end
            end
            PCU_UP:   inc = a_rise;
            PCU_UPDN: begin
                inc = a_rise & ~b_rise;
                dec = b_rise & ~a_rise;
            end
            PCU_PDIR: begin
                inc = a_rise & ~b;
                dec = a_rise & b;
            end
            default: inc = 1'b0;
        endcase
    end

    //------------------------------------------------------------------
    // Counter, ring maximum, error flag
    //------------------------------------------------------------------
    pcu_cnt_t cnt_r, ring_max_r;
    logic     err_r, ring_max_loaded_r;
    logic     bad_load;
    assign bad_load = ring_mode_i && !init_sel_max_i &&
                      (init_value_i > ring_max_r);
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ring_max_r        <= `PCU_RING_MAX_RST;
            ring_max_loaded_r <= 1'b0;
        end else if (!ring_max_loaded_r) begin
            ring_max_r        <= ring_max_cfg_i;
            ring_max_loaded_r <= 1'b1;
        end else if (value_init_instr_i && init_sel_max_i) begin
            ring_max_r        <= init_value_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cnt_r <= `PCU_CNT_RST;
        end else if (value_init_instr_i && !init_sel_max_i) begin
            cnt_r <= bad_load ? cnt_r : init_value_i;
        end else if (inc) begin
            if (ring_mode_i && cnt_r >= ring_max_r) begin
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + 32'h1;
            end
        end else if (dec) begin
            if (ring_mode_i && cnt_r == '0) begin
                cnt_r <= ring_max_r;
            end else begin
                cnt_r <= cnt_r - 32'h1;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            err_r <= 1'b0;
        end else if (value_init_instr_i) begin
            err_r <= bad_load;
        end
    end

    //------------------------------------------------------------------
    // Target and range comparison
    //------------------------------------------------------------------
    function automatic logic in_rng(input pcu_cnt_t v, input pcu_cnt_t lo,
                                    input pcu_cnt_t hi, input logic sgn);
        in_rng = sgn ?
            ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi)) :
            (v >= lo) && (v <= hi);
    endfunction
    logic [TGT_N-1:0] hit_r;
    logic [RNG_N-1:0] inr_r, revt_r;
    pcu_cnt_t         cnt_d_r;
    logic             sgn_r;
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cnt_d_r <= `PCU_CNT_RST;
            sgn_r   <= 1'b0;
        end else begin
            cnt_d_r <= cnt_r;
            sgn_r   <= !ring_mode_i;
        end
    end
    genvar gi;
    generate
        for (gi = 0; gi < TGT_N; gi++) begin : g_tgt
            always_ff @(posedge core_clk_i) begin
                if (rst_i) begin
                    hit_r[gi] <= 1'b0;
                end else begin
                    hit_r[gi] <= target_en_i[gi] && (cnt_r != cnt_d_r)
                                 && (cnt_r == target_i[gi]);
                end
            end
        end
        for (gi = 0; gi < RNG_N; gi++) begin : g_rng
            logic act;
            logic now_in;
            assign act    = range32_i || (gi < `PCU_RNG_NUM_MIN);
            assign now_in = act && in_rng(cnt_r, rng_lo_i[gi], rng_hi_i[gi],
                                          !ring_mode_i);
            always_ff @(posedge core_clk_i) begin
                if (rst_i) begin
                    inr_r[gi]  <= 1'b0;
                    revt_r[gi] <= 1'b0;
                end else begin
                    inr_r[gi]  <= now_in;
                    revt_r[gi] <= now_in ^ inr_r[gi];
                end
            end
        end
    endgenerate

    //------------------------------------------------------------------
    // Frequency sampling and reliability
    //------------------------------------------------------------------
    logic [SCW-1:0] smp_r;
    pcu_cnt_t       base_r, freq_r;
    logic           dirty_r, unrel_r;
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            smp_r   <= '0;
            base_r  <= '0;
            freq_r  <= '0;
            dirty_r <= 1'b0;
            unrel_r <= 1'b0;
        end else if (smp_r == SCW'(SAMPLE_C - 1)) begin
            smp_r   <= '0;
            base_r  <= cnt_r;
            freq_r  <= cnt_r - base_r;
            dirty_r <= 1'b0;
            unrel_r <= high_freq_mode_i && (dirty_r || value_init_instr_i);
        end else begin
            smp_r   <= smp_r + SCW'(1);
            if (value_init_instr_i && high_freq_mode_i) begin
                dirty_r <= 1'b1;
            end
        end
    end

    //------------------------------------------------------------------
    // Interrupt inputs and snapshots
    //------------------------------------------------------------------
    logic [IRQ_N-1:0] irq_w;
    logic [ICW-1:0]   ipv_w [IRQ_N];
    logic [ICW-1:0]   ipv_r [IRQ_N];
    pcu_cnt_t         snap_c_r, snap_p_r;
    generate
        for (gi = 0; gi < IRQ_N; gi++) begin : g_irq
            pcu_irq_input #(.CW(ICW)) u_irq (
                .core_clk_i   (core_clk_i),
                .rst_i        (rst_i),
                .edge_i       (irq_s2_r[gi] & ~irq_d_r[gi]),
                .count_mode_i (irq_count_mode_i[gi]),
                .global_dis_i (interrupt_disable_instr_i),
                .mask_set_i   (interrupt_mask_set_instr_i[gi]),
                .set_value_i  (irq_set_value_i[gi]),
                .init_i       (irq_init_i[gi]),
                .init_value_i (irq_init_value_i[gi]),
                .irq_o        (irq_w[gi]),
                .pv_o         (ipv_w[gi])
            );
            // Scan refresh each cycle covers completion and read too
            always_ff @(posedge core_clk_i) begin
                ipv_r[gi] <= rst_i ? '0 : ipv_w[gi];
            end
        end
    endgenerate

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            snap_c_r <= '0;
            snap_p_r <= '0;
        end else if (|irq_w) begin
            snap_c_r <= cnt_r;
            snap_p_r <= pulse_pv_i;
        end
    end

    a_snap_on_irq: assert property (@(posedge core_clk_i) disable iff (rst_i)
        |irq_w |=> snap_c_r == $past(cnt_r))
        else $error("Snapshot missed interrupt");
    a_ring_bad_err: assert property (@(posedge core_clk_i) disable iff (rst_i)
        value_init_instr_i && bad_load |=> err_r && $stable(cnt_r))
        else $error("Bad ring load not refused");
    a_ring_wrap_up: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ring_mode_i && inc && !value_init_instr_i && cnt_r == ring_max_r
        |=> cnt_r == '0)
        else $error("Ring did not wrap to zero");
    a_load_priority: assert property (@(posedge core_clk_i) disable iff (rst_i)
        value_init_instr_i && !init_sel_max_i && !bad_load && (inc || dec)
        |=> cnt_r == $past(init_value_i))
        else $error("Load lost to count");

    assign count_o                  = cnt_r;
    assign count_signed_o           = sgn_r;
    assign target_hit_o             = hit_r;
    assign range_evt_o              = revt_r;
    assign in_range_o               = inr_r;
    assign pv_change_error_flag_o   = err_r;
    assign result_unreliable_flag_o = unrel_r;
    assign freq_o                   = freq_r;
    assign irq_o                    = irq_w;
    assign irq_pv_o                 = ipv_r;
    assign snap_count_o             = snap_c_r;
    assign snap_pulse_o             = snap_p_r;
endmodule

// file: hw/pcu_params.svh
`ifndef PCU_PARAMS_SVH
`define PCU_PARAMS_SVH

// Count width and table sizes
`define PCU_CNT_W        32
`define PCU_TGT_NUM      48
`define PCU_RNG_NUM_MAX  32
`define PCU_RNG_NUM_MIN  8
`define PCU_IRQ_NUM      4
`define PCU_IRQ_CNT_W    16

// Counting mode encodings
`define PCU_MODE_QUAD    2'h0
`define PCU_MODE_UP      2'h1
`define PCU_MODE_UPDN    2'h2
`define PCU_MODE_PDIR    2'h3

// Reset values
`define PCU_RING_MAX_RST 32'hffffffff
`define PCU_CNT_RST      32'h00000000

// Time constants
`define PCU_CLK_MHZ      200
`define PCU_SAMPLE_US    10
`define PCU_SAMPLE_CYC   (`PCU_SAMPLE_US * `PCU_CLK_MHZ)

`endif

// file: hw/pcu_pkg.sv
package pcu_pkg;
    typedef logic [31:0] pcu_cnt_t;
    typedef enum logic [1:0] {
        PCU_QUAD = 2'h0,
        PCU_UP   = 2'h1,
        PCU_UPDN = 2'h2,
        PCU_PDIR = 2'h3
    } pcu_mode_t;
    // Gray order along idle -> armed -> fired
    typedef enum logic [1:0] {
        PCU_IRQ_IDLE  = 2'h0,
        PCU_IRQ_ARMED = 2'h1,
        PCU_IRQ_FIRED = 2'h3
    } pcu_irq_st_t;
endpackage

// file: hw/pcu_irq_input.sv
`timescale 1ns/10ps
`include "pcu_params.svh"

module pcu_irq_input
    import pcu_pkg::*;
#(
    parameter int CW = `PCU_IRQ_CNT_W
) (
    // Clock and reset
    input  wire logic          core_clk_i,
    input  wire logic          rst_i,
    // Synchronised edge and control
    input  wire logic          edge_i,
    input  wire logic          count_mode_i,
    input  wire logic          global_dis_i,
    input  wire logic          mask_set_i,
    input  wire logic [CW-1:0] set_value_i,
    input  wire logic          init_i,
    input  wire logic [CW-1:0] init_value_i,
    // Results
    output logic               irq_o,
    output logic [CW-1:0]      pv_o
);
    logic [CW-1:0] sv_r;
    logic [CW-1:0] pv_r;
    pcu_irq_st_t   st_r;
    logic          done;

    assign done = count_mode_i && edge_i && (st_r != PCU_IRQ_IDLE)
                  && (pv_r + CW'(1) >= sv_r);

    // Set value captured only at re-enable
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sv_r <= '0;
        end else if (mask_set_i) begin
            sv_r <= set_value_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            st_r <= PCU_IRQ_IDLE;
        end else begin
            case (st_r)
                PCU_IRQ_IDLE:  if (mask_set_i) st_r <= PCU_IRQ_ARMED;
                PCU_IRQ_ARMED: if (done) st_r <= PCU_IRQ_FIRED;
                PCU_IRQ_FIRED: if (mask_set_i) st_r <= PCU_IRQ_ARMED;
                default:       st_r <= PCU_IRQ_IDLE;
            endcase
        end
    end

    // Load beats count; counting goes on while globally disabled
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pv_r <= '0;
        end else if (init_i) begin
            pv_r <= init_value_i;
        end else if (mask_set_i) begin
            pv_r <= '0;
        end else if (done) begin
            pv_r <= '0;
        end else if (count_mode_i && edge_i) begin
            pv_r <= pv_r + CW'(1);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= !global_dis_i && (st_r != PCU_IRQ_IDLE) &&
                     (count_mode_i ? done : edge_i);
        end
    end

    assign pv_o = pv_r;

    a_disabled_no_irq: assert property (@(posedge core_clk_i) disable iff (rst_i)
        global_dis_i |=> !irq_o)
        else $error("Interrupt raised while globally disabled");
    a_direct_edge_irq: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !count_mode_i && edge_i && !global_dis_i && st_r != PCU_IRQ_IDLE
        |=> irq_o)
        else $error("Direct mode edge gave no interrupt");
    a_sv_only_on_mask: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !mask_set_i |=> $stable(sv_r))
        else $error("Set value changed without re-enable");
endmodule

// file: tb/pcu_pulse_src.sv
`timescale 1ns/10ps
module pcu_pulse_src (
    // Clock
    input  wire logic core_clk_i,
    // Pins toward the counter
    output logic      pin_a_o,
    output logic      pin_b_o
);
    // Long levels so every edge clears both sync stages
    localparam int HOLD = 6;

    initial begin
        pin_a_o = 1'b0;
        pin_b_o = 1'b0;
    end

    // Gray walk, one phase edge per step
    task automatic quad(input int steps, input bit rev);
        for (int i = 0; i < steps; i++) begin
            @(negedge core_clk_i);
            if ((pin_a_o ^ pin_b_o) == rev) begin
                pin_a_o = ~pin_a_o;
            end else begin
                pin_b_o = ~pin_b_o;
            end
            repeat (HOLD) @(negedge core_clk_i);
        end
    endtask

    // Single pulse on A or B
    task automatic pulse(input bit on_b);
        @(negedge core_clk_i);
        if (on_b) pin_b_o = 1'b1;
        else pin_a_o = 1'b1;
        repeat (HOLD) @(negedge core_clk_i);
        if (on_b) pin_b_o = 1'b0;
        else pin_a_o = 1'b0;
        repeat (HOLD) @(negedge core_clk_i);
    endtask

    // Direction level on B, 1 counts down
    task automatic set_dir(input bit down);
        @(negedge core_clk_i);
        pin_b_o = down;
        repeat (HOLD) @(negedge core_clk_i);
    endtask
endmodule

// file: tb/pulse_counter_interrupt_unit_tb_top.sv
`timescale 1ns/10ps
`include "pcu_params.svh"
module pulse_counter_interrupt_unit_tb_top import pcu_pkg::*;;
    localparam pcu_cnt_t PULSE_PV = 32'h00c0ffee;
    logic core_clk_i, rst_i, ring, init, sel_max, hf, rd, dis, clr, r32;
    logic pin_a, pin_b, sgn, perr, unrel, hit_s, revt_s;
    pcu_mode_t mode;
    pcu_cnt_t init_v, cnt, fq, snap_c, snap_p;
    pcu_cnt_t tgt [`PCU_TGT_NUM];
    pcu_cnt_t rlo [`PCU_RNG_NUM_MAX];
    pcu_cnt_t rhi [`PCU_RNG_NUM_MAX];
    logic [`PCU_TGT_NUM-1:0] tgt_en, hit;
    logic [31:0] revt, inr;
    logic [3:0] ipin, icm, imask, irq, irq_s, iinit;
    logic [15:0] isv [4];
    logic [15:0] ival [4];
    logic [15:0] ipv [4];
    int checked, bad_count, cyc;

    pcu_pulse_src u_pcu_pulse_src (.core_clk_i(core_clk_i),
        .pin_a_o(pin_a), .pin_b_o(pin_b));

    pcu_core #(.SAMPLE_C(8)) u_pcu_core (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .pin_a_i(pin_a),
        .pin_b_i(pin_b), .mode_i(mode), .ring_mode_i(ring),
        .ring_max_cfg_i(32'h00000009), .range32_i(r32),
        .value_init_instr_i(init), .init_sel_max_i(sel_max),
        .init_value_i(init_v), .target_i(tgt), .target_en_i(tgt_en),
        .rng_lo_i(rlo), .rng_hi_i(rhi), .high_freq_mode_i(hf),
        .value_read_instr_i(rd), .irq_pin_i(ipin),
        .irq_count_mode_i(icm), .interrupt_disable_instr_i(dis),
        .interrupt_mask_set_instr_i(imask), .irq_set_value_i(isv),
        .irq_init_i(iinit), .irq_init_value_i(ival),
        .pulse_pv_i(PULSE_PV), .count_o(cnt), .count_signed_o(sgn),
        .target_hit_o(hit), .range_evt_o(revt), .in_range_o(inr),
        .pv_change_error_flag_o(perr), .result_unreliable_flag_o(unrel),
        .freq_o(fq), .irq_o(irq), .irq_pv_o(ipv),
        .snap_count_o(snap_c), .snap_pulse_o(snap_p));

    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    // One-cycle pulses are caught here so tasks can look later
    always @(posedge core_clk_i) begin
        cyc <= rst_i ? 0 : cyc + 1;
        hit_s <= (clr || rst_i) ? 1'b0 : hit_s | hit[0];
        revt_s <= (clr || rst_i) ? 1'b0 : revt_s | revt[0];
        irq_s <= (clr || rst_i) ? 4'h0 : irq_s | irq;
        if (cyc == 20000) begin
            bad_count++;
            stop_test();
        end
    end

    //----------------------------------------------------------------
    // Helpers
    //----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            $display("wrong value %s exp %h seen %h", what, exp, seen);
            bad_count++;
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic load(input pcu_cnt_t v, input bit max);
        @(negedge core_clk_i);
        init_v = v;
        sel_max = max;
        init = 1'b1;
        @(negedge core_clk_i);
        init = 1'b0;
        repeat (3) @(negedge core_clk_i);
    endtask

    task automatic clear();
        @(negedge core_clk_i);
        clr = 1'b1;
        @(negedge core_clk_i);
        clr = 1'b0;
    endtask

    task automatic mask(input int i);
        @(negedge core_clk_i);
        imask[i] = 1'b1;
        @(negedge core_clk_i);
        imask = 4'h0;
        clear();
    endtask

    task automatic iedge(input int i);
        @(negedge core_clk_i);
        ipin[i] = 1'b1;
        repeat (6) @(negedge core_clk_i);
        ipin[i] = 1'b0;
        repeat (6) @(negedge core_clk_i);
    endtask

    //----------------------------------------------------------------
    // Scenarios
    //----------------------------------------------------------------
    task automatic t_modes();
        mode = PCU_QUAD;
        load(32'h0, 1'b0);
        u_pcu_pulse_src.quad(4, 1'b0);
        chk("quad x4", cnt, 32'h4);
        u_pcu_pulse_src.quad(4, 1'b1);
        chk("quad back", cnt, 32'h0);
        mode = PCU_UP;
        u_pcu_pulse_src.pulse(1'b0);
        u_pcu_pulse_src.pulse(1'b1);
        chk("up only", cnt, 32'h1);
        mode = PCU_UPDN;
        u_pcu_pulse_src.pulse(1'b1);
        chk("updn down", cnt, 32'h0);
        mode = PCU_PDIR;
        u_pcu_pulse_src.pulse(1'b0);
        u_pcu_pulse_src.set_dir(1'b1);
        u_pcu_pulse_src.pulse(1'b0);
        u_pcu_pulse_src.pulse(1'b0);
        chk("pulse dir", cnt, 32'hffffffff);
        u_pcu_pulse_src.set_dir(1'b0);
        mode = PCU_UP;
        load(32'h7fffffff, 1'b0);
        u_pcu_pulse_src.pulse(1'b0);
        chk("linear signed", cnt, 32'h80000000);
        chk("signed view", {31'h0, sgn}, 32'h1);
    endtask

    task automatic t_ring();
        ring = 1'b1;
        load(32'h9, 1'b0);
        chk("cfg max load", cnt, 32'h9);
        chk("ring unsigned", {31'h0, sgn}, 32'h0);
        load(32'h5, 1'b1);
        load(32'h6, 1'b0);
        chk("above max", {31'h0, perr}, 32'h1);
        chk("load ignored", cnt, 32'h9);
        load(32'h5, 1'b0);
        chk("good load", {31'h0, perr}, 32'h0);
        u_pcu_pulse_src.pulse(1'b0);
        chk("wrap up", cnt, 32'h0);
        mode = PCU_UPDN;
        u_pcu_pulse_src.pulse(1'b1);
        chk("wrap down", cnt, 32'h5);
        mode = PCU_UP;
        ring = 1'b0;
    endtask

    task automatic t_compare();
        load(32'h6, 1'b0);
        clear();
        u_pcu_pulse_src.pulse(1'b0);
        chk("target hit", {31'h0, hit_s}, 32'h1);
        chk("range enter", {31'h0, revt_s}, 32'h1);
        chk("in range", {31'h0, inr[0]}, 32'h1);
        chk("range 31 on", {31'h0, inr[31]}, 32'h1);
        r32 = 1'b0;
        repeat (2) @(negedge core_clk_i);
        chk("range 31 off", {31'h0, inr[31]}, 32'h0);
        chk("range 0 kept", {31'h0, inr[0]}, 32'h1);
        r32 = 1'b1;
        tgt_en = 48'h0;
        load(32'h6, 1'b0);
        clear();
        u_pcu_pulse_src.pulse(1'b0);
        chk("target off", {31'h0, hit_s}, 32'h0);
        tgt_en = 48'h1;
        load(32'h9, 1'b0);
        clear();
        u_pcu_pulse_src.pulse(1'b0);
        chk("no false hit", {31'h0, hit_s}, 32'h0);
        chk("range leave", {31'h0, revt_s}, 32'h1);
        chk("left range", {31'h0, inr[0]}, 32'h0);
    endtask

    task automatic t_irq();
        mask(0);
        iedge(0);
        chk("direct irq", {28'h0, irq_s}, 32'h1);
        chk("snap count", snap_c, 32'ha);
        chk("snap pulse", snap_p, PULSE_PV);
        icm = 4'h2;
        isv[1] = 16'h0003;
        mask(1);
        iedge(1);
        iedge(1);
        rd = 1'b1;
        @(negedge core_clk_i);
        rd = 1'b0;
        chk("irq pv", {16'h0, ipv[1]}, 32'h2);
        chk("no early irq", {28'h0, irq_s}, 32'h0);
        iedge(1);
        chk("count irq", {28'h0, irq_s}, 32'h2);
        dis = 1'b1;
        clear();
        iedge(1);
        iedge(1);
        chk("pv disabled", {16'h0, ipv[1]}, 32'h2);
        iedge(1);
        chk("irq held off", {28'h0, irq_s}, 32'h0);
        chk("pv restarted", {16'h0, ipv[1]}, 32'h0);
        dis = 1'b0;
        isv[1] = 16'h0001;
        iedge(1);
        chk("old sv kept", {28'h0, irq_s}, 32'h0);
        isv[1] = 16'h0002;
        mask(1);
        iedge(1);
        chk("pv cleared", {16'h0, ipv[1]}, 32'h1);
        iedge(1);
        chk("new sv", {28'h0, irq_s}, 32'h2);
        ival[1] = 16'h0005;
        @(negedge core_clk_i);
        iinit[1] = 1'b1;
        @(negedge core_clk_i);
        iinit = 4'h0;
        repeat (2) @(negedge core_clk_i);
        chk("irq pv init", {16'h0, ipv[1]}, 32'h5);
    endtask

    task automatic t_unrel();
        logic seen;
        hf = 1'b1;
        repeat (30) @(negedge core_clk_i);
        chk("steady reliable", {31'h0, unrel}, 32'h0);
        chk("idle freq", fq, 32'h0);
        load(32'h3, 1'b0);
        // Flag stands one window only, so watch for it
        seen = 1'b0;
        repeat (10) begin
            @(negedge core_clk_i);
            seen = seen | unrel;
        end
        chk("unreliable", {31'h0, seen}, 32'h1);
    endtask

    initial begin
        {ring, init, sel_max, hf, rd, dis, clr, r32} = 8'h01;
        {ipin, icm, imask, iinit} = 16'h0;
        mode = PCU_QUAD;
        init_v = 32'h0;
        checked = 0;
        bad_count = 0;
        tgt_en = 48'h1;
        for (int i = 0; i < `PCU_TGT_NUM; i++) tgt[i] = 32'h7;
        for (int i = 0; i < `PCU_RNG_NUM_MAX; i++) begin
            rlo[i] = 32'h7;
            rhi[i] = 32'h9;
        end
        for (int i = 0; i < 4; i++) begin
            isv[i] = 16'h0;
            ival[i] = 16'h0;
        end
        rst_i = 1'b1;
        repeat (8) @(negedge core_clk_i);
        rst_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        t_modes();
        t_ring();
        t_compare();
        t_irq();
        t_unrel();
        stop_test();
    end
endmodule
